// >>> eis_pkg.sv
// Purpose: Constants for the Ethernet event flag register block.
// Assumes: APB slave with 32-bit data and byte addresses.
// Notes: Bit positions follow the event flag register layout.
package eis_pkg;

  // ==========================================================================
  // Register offsets.
  // ==========================================================================
  localparam logic [7:0] EIS_OFS_EVENT_FLAG = 8'h58;
  localparam logic [7:0] EIS_OFS_EVENT_SRC = 8'h70;
  localparam logic [7:0] EIS_OFS_BYTE_TEST = 8'h64;
  localparam logic [7:0] EIS_OFS_CONTROL = 8'h74;

  // ==========================================================================
  // Field positions in the event flag register.
  // ==========================================================================
  localparam int EIS_BIT_SW = 31;
  localparam int EIS_BIT_TX_HALT = 25;
  localparam int EIS_BIT_RX_HALT = 24;
  localparam int EIS_BIT_DROP_MID = 23;
  localparam int EIS_BIT_BUF_DONE = 21;
  localparam int EIS_BIT_RX_XFER = 20;
  localparam int EIS_BIT_TIMER = 19;
  localparam int EIS_BIT_PHY = 18;
  localparam int EIS_BIT_POWER = 17;
  localparam int EIS_BIT_TXS_OVF = 16;
  localparam int EIS_BIT_RX_WDOG = 15;
  localparam int EIS_BIT_RX_ERR = 14;
  localparam int EIS_BIT_TX_ERR = 13;
  localparam int EIS_BIT_TXD_UNDER = 11;
  localparam int EIS_BIT_TXD_OVER = 10;
  localparam int EIS_BIT_TXD_AVAIL = 9;
  localparam int EIS_BIT_TXS_FULL = 8;
  localparam int EIS_BIT_TXS_LEVEL = 7;
  localparam int EIS_BIT_RX_DROP = 6;
  localparam int EIS_BIT_RXD_LEVEL = 5;
  localparam int EIS_BIT_RXS_FULL = 4;
  localparam int EIS_BIT_RXS_LEVEL = 3;
  localparam int EIS_BIT_PIN_HI = 2;

  // Control register fields.
  localparam int EIS_CTL_SW_EN = 0;
  localparam int EIS_CTL_SLEEP = 1;

  // Writable sticky flag positions (bit 18 and reserved bits excluded).
  localparam logic [31:0] EIS_STICKY_MASK = 32'h83BB_EFFF;
  localparam logic [31:0] EIS_FLAG_RESET = 32'h0000_0000;

  // Drop counter values around its midpoint, timer values at its wrap, and the byte test word.
  localparam logic [31:0] EIS_DROP_BEFORE = 32'h7FFF_FFFF;
  localparam logic [31:0] EIS_DROP_AFTER = 32'h8000_0000;
  localparam logic [15:0] EIS_TIMER_ZERO = 16'h0000;
  localparam logic [15:0] EIS_TIMER_WRAP = 16'hFFFF;
  localparam logic [31:0] EIS_BYTE_TEST_VAL = 32'h8765_4321;

  // Receive watchdog length limit in bytes.
  localparam logic [15:0] EIS_RX_LEN_LIMIT = 16'h0800;

  // Power state machine, one-hot.
  typedef enum logic [1:0] {
    EIS_PWR_AWAKE = 2'b01,
    EIS_PWR_SLEEP = 2'b10
  } eis_pwr_t;

endpackage : eis_pkg

// >>> eis_event_flags.sv
// Purpose: Sticky event flag register of a 10/100 Ethernet controller, on APB.
// Assumes: Event inputs come from logic on mclk_in; pin events pass a synchroniser.
// Notes: Flags are sticky; each rule below names the bit that it governs, except R1, R11, R12, R23 and R24.
// Contract
// [R1] Host write of one clears a flag; zero leaves it; register at 58h.
// [R2] Software flag bit 31 sets while software enable is high; write one clears.
// [R3] Bit 25 sets when stop was requested and transmitter has halted.
// [R4] Bit 24 sets when the receive engine halts.
// [R5] Bit 23 sets when drop counter goes 7FFFFFFFh to 80000000h.
// [R6] Bit 21 sets when a completion-marked buffer is fully loaded.
// [R7] Bit 20 sets when the programmed receive transfer count has moved out.
// [R8] Bit 19 sets when the timer wraps from zero to FFFFh.
// [R9] Bit 18 is read-only, mirrors the transceiver event, writes ignored.
// [R10] Bit 17 sets on power event even with wake pin disabled; write clears.
// [R11] Power events never wake the device; only a byte test write does.
// [R12] Hold-off interval never gates the power event flag.
// [R13] Bit 16 sets on transmit status FIFO overflow.
// [R14] Bit 15 sets on a received packet longer than 2048 bytes.
// [R15] Bit 14 on receiver error, bit 13 on transmitter error.
// [R16] Bit 11 sets on transmit data FIFO underrun.
// [R17] Bit 10 sets on a write to a full transmit data FIFO.
// [R18] Bit 9 sets when transmit free space exceeds its threshold.
// [R19] Bit 8 on transmit status full, bit 4 on receive status full.
// [R20] Bits 7, 5, 3 set when their FIFOs reach programmed levels.
// [R21] Bit 6 sets each time a receive frame is dropped.
// [R22] Bits 2..0 latch pin events; write one clears; reset 000.
// [R23] Flags record events regardless of any enable mask.
// [R24] An event in the same cycle as a clear keeps the flag set.
`timescale 1ns/1ps
`default_nettype none

module eis_event_flags (
  // Clock, reset and clock enable.
  input wire logic mclk_in,
  input wire logic reset_n_in,
  input wire logic clk_en_in,
  // APB slave.
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Event sources, one-cycle pulses or levels from core logic.
  input wire logic tx_stop_req_in,
  input wire logic tx_halted_in,
  input wire logic rx_halted_in,
  input wire logic drop_count_inc_in,
  input wire logic [31:0] drop_count_in,
  input wire logic buffer_loaded_in,
  input wire logic completion_marker_in,
  input wire logic rx_xfer_done_in,
  input wire logic timer_dec_in,
  input wire logic [15:0] timer_value_in,
  input wire logic transceiver_event_in,
  input wire logic power_event_in,
  input wire logic tx_status_overflow_in,
  input wire logic rx_frame_end_in,
  input wire logic [15:0] rx_frame_len_in,
  input wire logic rx_error_in,
  input wire logic tx_error_in,
  input wire logic tx_data_underrun_in,
  input wire logic tx_fifo_write_in,
  input wire logic tx_data_full_in,
  input wire logic tx_space_above_in,
  input wire logic tx_status_full_in,
  input wire logic tx_status_level_in,
  input wire logic frame_dropped_in,
  input wire logic rx_data_level_in,
  input wire logic rx_status_full_in,
  input wire logic rx_status_level_in,
  input wire logic [eis_pkg::EIS_BIT_PIN_HI:0] pin_event_in,
  // Status outputs.
  output logic [31:0] event_flags_out,
  output logic asleep_out
);
  import eis_pkg::*;

  // ==========================================================================
  // Pin event synchroniser.
  // ==========================================================================
  logic [EIS_BIT_PIN_HI:0] pin_meta_reg;
  logic [EIS_BIT_PIN_HI:0] pin_sync_reg;
  logic [EIS_BIT_PIN_HI:0] pin_prev_reg;

  // Two stages then an edge memory; only the second stage feeds the detector.
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
      pin_prev_reg <= '0;
    end else if (clk_en_in) begin
      pin_meta_reg <= pin_event_in;
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
    end
  end

  // ==========================================================================
  // APB decode.
  // ==========================================================================
  logic apb_access;
  logic apb_wr;
  logic apb_rd;
  logic addr_hit;

  // Every access completes in its first access cycle; unmapped gives an error.
  always_comb begin
    apb_access = psel_in && penable_in && clk_en_in;
    apb_wr = apb_access && pwrite_in;
    apb_rd = apb_access && !pwrite_in;
    addr_hit = (paddr_in == EIS_OFS_EVENT_FLAG) || (paddr_in == EIS_OFS_BYTE_TEST) ||
               (paddr_in == EIS_OFS_CONTROL) || (paddr_in == EIS_OFS_EVENT_SRC);
    pready_out = 1'b1;
    pslverr_out = psel_in && penable_in && !addr_hit;
  end

  // ==========================================================================
  // Event set vector.
  // ==========================================================================
  logic [31:0] flag_reg;
  logic [31:0] flag_next;
  logic [31:0] set_vec;
  logic [31:0] clr_vec;
  logic [1:0] ctrl_reg;
  logic [1:0] ctrl_next;

  // Events are gathered with no mask at all, so status always records them.
  always_comb begin
    set_vec = '0;
    set_vec[EIS_BIT_SW] = ctrl_reg[EIS_CTL_SW_EN]; // see [R2] see [R23]
    set_vec[EIS_BIT_TX_HALT] = tx_stop_req_in && tx_halted_in; // see [R3]
    set_vec[EIS_BIT_RX_HALT] = rx_halted_in; // see [R4]
    set_vec[EIS_BIT_DROP_MID] = drop_count_inc_in &&
                                (drop_count_in == EIS_DROP_BEFORE); // see [R5]
    set_vec[EIS_BIT_BUF_DONE] = buffer_loaded_in && completion_marker_in; // see [R6]
    set_vec[EIS_BIT_RX_XFER] = rx_xfer_done_in; // see [R7]
    set_vec[EIS_BIT_TIMER] = timer_dec_in && (timer_value_in == EIS_TIMER_ZERO); // see [R8]
    // The power flag takes the raw event, untouched by any hold-off timing.
    set_vec[EIS_BIT_POWER] = power_event_in; // see [R10] see [R12]
    set_vec[EIS_BIT_TXS_OVF] = tx_status_overflow_in; // see [R13]
    set_vec[EIS_BIT_RX_WDOG] = rx_frame_end_in &&
                               (rx_frame_len_in > EIS_RX_LEN_LIMIT); // see [R14]
    set_vec[EIS_BIT_RX_ERR] = rx_error_in; // see [R15]
    set_vec[EIS_BIT_TX_ERR] = tx_error_in; // see [R15]
    set_vec[EIS_BIT_TXD_UNDER] = tx_data_underrun_in; // see [R16]
    set_vec[EIS_BIT_TXD_OVER] = tx_fifo_write_in && tx_data_full_in; // see [R17]
    set_vec[EIS_BIT_TXD_AVAIL] = tx_space_above_in; // see [R18]
    set_vec[EIS_BIT_TXS_FULL] = tx_status_full_in; // see [R19]
    set_vec[EIS_BIT_RXS_FULL] = rx_status_full_in; // see [R19]
    set_vec[EIS_BIT_TXS_LEVEL] = tx_status_level_in; // see [R20]
    set_vec[EIS_BIT_RXD_LEVEL] = rx_data_level_in; // see [R20]
    set_vec[EIS_BIT_RXS_LEVEL] = rx_status_level_in; // see [R20]
    set_vec[EIS_BIT_RX_DROP] = frame_dropped_in; // see [R21]
    // Rising edge of each synchronised pin event.
    set_vec[EIS_BIT_PIN_HI:0] = pin_sync_reg & ~pin_prev_reg; // see [R22]
  end

  // ==========================================================================
  // Sticky flags.
  // ==========================================================================
  // Clears only touch writable sticky positions; set beats clear.
  always_comb begin
    clr_vec = '0;
    if (apb_wr && paddr_in == EIS_OFS_EVENT_FLAG) begin
      clr_vec = pwdata_in & EIS_STICKY_MASK; // see [R1]
    end
    flag_next = ((flag_reg & ~clr_vec) | set_vec) & EIS_STICKY_MASK; // see [R24]
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      flag_reg <= EIS_FLAG_RESET;
    end else if (clk_en_in) begin
      flag_reg <= flag_next;
    end
  end

  // ==========================================================================
  // Control register and power state.
  // ==========================================================================
  eis_pwr_t pwr_reg;
  eis_pwr_t pwr_next;

  // Only a byte test write leaves sleep; power events are deliberately ignored.
  always_comb begin
    ctrl_next = ctrl_reg;
    pwr_next = pwr_reg;
    if (apb_wr && paddr_in == EIS_OFS_CONTROL) begin
      ctrl_next = pwdata_in[1:0];
    end
    case (pwr_reg)
      EIS_PWR_AWAKE: begin
        if (ctrl_next[EIS_CTL_SLEEP]) begin
          pwr_next = EIS_PWR_SLEEP;
        end
      end
      EIS_PWR_SLEEP: begin
        if (apb_wr && paddr_in == EIS_OFS_BYTE_TEST) begin
          pwr_next = EIS_PWR_AWAKE; // see [R11]
          ctrl_next[EIS_CTL_SLEEP] = 1'b0;
        end
      end
      default: begin
        pwr_next = EIS_PWR_AWAKE;
      end
    endcase
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ctrl_reg <= 2'b00;
      pwr_reg <= EIS_PWR_AWAKE;
    end else if (clk_en_in) begin
      ctrl_reg <= ctrl_next;
      pwr_reg <= pwr_next;
    end
  end

  // ==========================================================================
  // Read data.
  // ==========================================================================
  logic [31:0] rd_reg;
  logic [31:0] rd_next;
  logic [31:0] view_flags;

  // Bit 18 is a live mirror and has no storage, so a write cannot clear it.
  always_comb begin
    view_flags = flag_reg;
    view_flags[EIS_BIT_PHY] = transceiver_event_in; // see [R9]
    rd_next = rd_reg;
    if (psel_in && !penable_in && !pwrite_in) begin
      case (paddr_in)
        EIS_OFS_EVENT_FLAG: rd_next = view_flags;
        EIS_OFS_BYTE_TEST: rd_next = EIS_BYTE_TEST_VAL;
        EIS_OFS_CONTROL: rd_next = {30'h0000_0000, ctrl_reg};
        EIS_OFS_EVENT_SRC: rd_next = set_vec;
        default: rd_next = 32'h0000_0000;
      endcase
    end
  end

  // Data is captured in the setup cycle so it stands for the access cycle.
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rd_reg <= 32'h0000_0000;
    end else if (clk_en_in) begin
      rd_reg <= rd_next;
    end
  end

  // Flag output is registered apart from the live transceiver bit.
  always_comb begin
    prdata_out = rd_reg;
    event_flags_out = view_flags;
    asleep_out = (pwr_reg == EIS_PWR_SLEEP);
  end

  // ==========================================================================
  // Checks.
  // ==========================================================================
  wrclr_keeps_zero_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // see [R1]
    (clk_en_in && apb_wr && paddr_in == EIS_OFS_EVENT_FLAG && flag_reg[EIS_BIT_RX_ERR]
     && !pwdata_in[EIS_BIT_RX_ERR]) |=> flag_reg[EIS_BIT_RX_ERR])
    else $error("Writing zero cleared a flag.");

  sw_flag_set_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // see [R2]
    (clk_en_in && ctrl_reg[EIS_CTL_SW_EN]) |=> flag_reg[EIS_BIT_SW])
    else $error("Software flag not set while enabled.");

  drop_mid_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // see [R5]
    (clk_en_in && drop_count_inc_in && drop_count_in == EIS_DROP_BEFORE)
    |=> flag_reg[EIS_BIT_DROP_MID])
    else $error("Drop midpoint flag missed.");

  timer_wrap_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // see [R8]
    (clk_en_in && timer_dec_in && timer_value_in == EIS_TIMER_ZERO)
    |=> flag_reg[EIS_BIT_TIMER])
    else $error("Timer wrap flag missed.");

  phy_mirror_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // see [R9]
    event_flags_out[EIS_BIT_PHY] == transceiver_event_in && !flag_reg[EIS_BIT_PHY])
    else $error("Transceiver bit is not a live mirror.");

  power_set_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // see [R10]
    (clk_en_in && power_event_in) |=> flag_reg[EIS_BIT_POWER])
    else $error("Power event flag missed.");

  sleep_hold_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // see [R11]
    (asleep_out && !(apb_wr && paddr_in == EIS_OFS_BYTE_TEST)) |=> asleep_out)
    else $error("Device woke without a byte test write.");

  wdog_len_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // see [R14]
    (clk_en_in && rx_frame_end_in && rx_frame_len_in > EIS_RX_LEN_LIMIT)
    |=> flag_reg[EIS_BIT_RX_WDOG])
    else $error("Watchdog flag missed on long frame.");

  pin_edge_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // see [R22]
    (clk_en_in && $rose(pin_sync_reg[0])) |=> flag_reg[0])
    else $error("Pin event flag missed.");

  set_wins_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // see [R24]
    (clk_en_in && apb_wr && paddr_in == EIS_OFS_EVENT_FLAG && rx_error_in)
    |=> flag_reg[EIS_BIT_RX_ERR])
    else $error("Event lost to a same-cycle clear.");

  tx_halt_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // see [R3]
    (clk_en_in && tx_stop_req_in && tx_halted_in) |=> flag_reg[EIS_BIT_TX_HALT])
    else $error("Transmit halt flag missed.");

  rx_halt_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // see [R4]
    (clk_en_in && rx_halted_in) |=> flag_reg[EIS_BIT_RX_HALT])
    else $error("Receive halt flag missed.");

  buf_done_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // see [R6]
    (clk_en_in && buffer_loaded_in && completion_marker_in) |=> flag_reg[EIS_BIT_BUF_DONE])
    else $error("Buffer completion flag missed.");

  rx_xfer_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // see [R7]
    (clk_en_in && rx_xfer_done_in) |=> flag_reg[EIS_BIT_RX_XFER])
    else $error("Receive transfer flag missed.");

  txs_ovf_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // see [R13]
    (clk_en_in && tx_status_overflow_in) |=> flag_reg[EIS_BIT_TXS_OVF])
    else $error("Status overflow flag missed.");

  rx_err_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // see [R15]
    (clk_en_in && rx_error_in) |=> flag_reg[EIS_BIT_RX_ERR])
    else $error("Receiver error flag missed.");

  tx_err_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // see [R15]
    (clk_en_in && tx_error_in) |=> flag_reg[EIS_BIT_TX_ERR])
    else $error("Transmitter error flag missed.");

  txd_under_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // see [R16]
    (clk_en_in && tx_data_underrun_in) |=> flag_reg[EIS_BIT_TXD_UNDER])
    else $error("Underrun flag missed.");

  txd_over_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // see [R17]
    (clk_en_in && tx_fifo_write_in && tx_data_full_in) |=> flag_reg[EIS_BIT_TXD_OVER])
    else $error("Overrun flag missed.");

  txd_avail_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // see [R18]
    (clk_en_in && tx_space_above_in) |=> flag_reg[EIS_BIT_TXD_AVAIL])
    else $error("Space available flag missed.");

  txs_full_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // see [R19]
    (clk_en_in && tx_status_full_in) |=> flag_reg[EIS_BIT_TXS_FULL])
    else $error("Transmit status full flag missed.");

  rxs_full_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // see [R19]
    (clk_en_in && rx_status_full_in) |=> flag_reg[EIS_BIT_RXS_FULL])
    else $error("Receive status full flag missed.");

  txs_level_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // see [R20]
    (clk_en_in && tx_status_level_in) |=> flag_reg[EIS_BIT_TXS_LEVEL])
    else $error("Transmit status level flag missed.");

  rx_drop_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // see [R21]
    (clk_en_in && frame_dropped_in) |=> flag_reg[EIS_BIT_RX_DROP])
    else $error("Dropped frame flag missed.");

  read_keeps_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // see [R1]
    (apb_rd && flag_reg[EIS_BIT_RX_ERR]) |=> flag_reg[EIS_BIT_RX_ERR])
    else $error("A read cleared a flag.");

  enable_freeze_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    !clk_en_in |=> $stable(flag_reg) && $stable(ctrl_reg) && $stable(pwr_reg))
    else $error("State moved while the clock enable was low.");

endmodule : eis_event_flags

`default_nettype wire

// >>> eis_host_model.sv
// Purpose: Host model that drives APB transfers into the event flag block.
// Assumes: The caller starts each transfer just after a rising clock edge.
// Notes: Waits on pready are bounded so a dead slave cannot hang the run.
`timescale 1ns/1ps
`default_nettype none

module eis_host_model (
  // Clock.
  input wire logic mclk_in,
  // Slave answer.
  input wire logic [31:0] prdata_in,
  input wire logic pready_in,
  input wire logic pslverr_in,
  // Request.
  output var logic psel_out,
  output var logic penable_out,
  output var logic pwrite_out,
  output var logic [7:0] paddr_out,
  output var logic [31:0] pwdata_out
);
  // ==========================================================================
  // Bus transfer.
  // ==========================================================================
  // The bus idles at time zero so the slave never sees an unknown select.
  initial begin
    psel_out = 1'b0;
    penable_out = 1'b0;
    pwrite_out = 1'b0;
    paddr_out = 8'h00;
    pwdata_out = 32'h0000_0000;
  end

  // One setup cycle, then access until pready; an idle edge follows so that
  // a transfer started at once never assigns the select twice in one step.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic e, output logic to);
    int n;
    n = 0;
    psel_out <= 1'b1;
    penable_out <= 1'b0;
    pwrite_out <= w;
    paddr_out <= a;
    pwdata_out <= d;
    @(posedge mclk_in);
    penable_out <= 1'b1;
    @(posedge mclk_in);
    while (pready_in !== 1'b1 && n < 16) begin
      n++;
      @(posedge mclk_in);
    end
    q = prdata_in;
    e = pslverr_in;
    to = (n >= 16);
    psel_out <= 1'b0;
    penable_out <= 1'b0;
    @(posedge mclk_in);
  endtask : xfer
endmodule : eis_host_model

`default_nettype wire

// >>> eis_event_flags_bench.sv
// Purpose: Self-checking bench for the event flag register block.
// Assumes: Zero wait state APB slave; events sampled on the rising edge.
// Notes: Random event vectors mix with directed corner cases.
`timescale 1ns/1ps
`default_nettype none

module eis_event_flags_bench;
  import eis_pkg::*;
  logic mclk_in, reset_n_in, psel, penable, pwrite, pready, pslverr, phy, asleep, err, en;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, flags, dc, q;
  logic [22:0] ev;
  logic [15:0] tv, ln;
  logic [2:0] pins;
  int num_errors = 0;
  int checked = 0;

  // ==========================================================================
  // Design and host model.
  // ==========================================================================
  // Every input is driven, the clock enable too, so a freeze can be tested.
  eis_event_flags eis_event_flags_i (
    .mclk_in(mclk_in), .reset_n_in(reset_n_in), .clk_en_in(en),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .tx_stop_req_in(ev[0]), .tx_halted_in(ev[1]), .rx_halted_in(ev[2]),
    .drop_count_inc_in(ev[3]), .drop_count_in(dc), .buffer_loaded_in(ev[4]),
    .completion_marker_in(ev[5]), .rx_xfer_done_in(ev[6]), .timer_dec_in(ev[7]),
    .timer_value_in(tv), .transceiver_event_in(phy), .power_event_in(ev[8]),
    .tx_status_overflow_in(ev[9]), .rx_frame_end_in(ev[10]), .rx_frame_len_in(ln),
    .rx_error_in(ev[11]), .tx_error_in(ev[12]), .tx_data_underrun_in(ev[13]),
    .tx_fifo_write_in(ev[14]), .tx_data_full_in(ev[15]), .tx_space_above_in(ev[16]),
    .tx_status_full_in(ev[17]), .tx_status_level_in(ev[18]), .frame_dropped_in(ev[19]),
    .rx_data_level_in(ev[20]), .rx_status_full_in(ev[21]), .rx_status_level_in(ev[22]),
    .pin_event_in(pins), .event_flags_out(flags), .asleep_out(asleep)
  );

  eis_host_model eis_host_model_i (
    .mclk_in(mclk_in), .prdata_in(prdata), .pready_in(pready), .pslverr_in(pslverr),
    .psel_out(psel), .penable_out(penable), .pwrite_out(pwrite), .paddr_out(paddr),
    .pwdata_out(pwdata)
  );

  // ==========================================================================
  // Expectation and checking.
  // ==========================================================================
  // Flags expected after one cycle of the given event vector.
  function automatic logic [31:0] expect_flags(logic [22:0] e, logic [31:0] d,
      logic [15:0] t, logic [15:0] l);
    logic [31:0] f;
    f = 32'h0000_0000;
    f[25] = e[0] & e[1];
    f[24] = e[2];
    f[23] = e[3] & (d == 32'h7FFF_FFFF);
    f[21] = e[4] & e[5];
    f[20] = e[6];
    f[19] = e[7] & (t == 16'h0000);
    // The power event drives bit 17 and the status overflow bit 16.
    f[17:16] = {e[8], e[9]};
    f[15] = e[10] & (l > 16'h0800);
    f[14:13] = {e[11], e[12]};
    f[11] = e[13];
    f[10] = e[14] & e[15];
    f[9:3] = {e[16], e[17], e[18], e[19], e[20], e[21], e[22]};
    return f;
  endfunction : expect_flags

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // A transfer that never completes ends the run at once.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic to;
    eis_host_model_i.xfer(w, a, d, q, err, to);
    if (to !== 1'b0) begin
      num_errors++;
      give_verdict();
    end
  endtask : xfer

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0000_0000);
    chk(q, exp);
  endtask : rdc

  task automatic give_verdict();
    $display("errors=%0d comparisons=%0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : give_verdict

  // ==========================================================================
  // Stimulus.
  // ==========================================================================
  initial begin
    mclk_in = 1'b0;
    forever #20 mclk_in = ~mclk_in;
  end

  // Sequence: reset, refusal, random events, then directed corners.
  initial begin
    logic [22:0] e;
    logic [31:0] d, x, w;
    logic [15:0] t, l;
    reset_n_in = 1'b0;
    ev = '0;
    dc = 32'h0000_0000;
    tv = 16'h0000;
    ln = 16'h0000;
    phy = 1'b0;
    pins = 3'b000;
    en = 1'b1;
    void'($urandom(87223));
    repeat (6) @(posedge mclk_in);
    reset_n_in <= 1'b1;
    @(posedge mclk_in);
    rdc(8'h58, 32'h0000_0000);
    chk({31'h0, asleep}, 32'h0000_0000);
    xfer(1'b0, 8'h10, 32'h0000_0000);
    chk({q[31:1], err}, 32'h0000_0001);
    // Counter and length operands straddle their boundaries.
    repeat (30) begin
      e = 23'($urandom);
      d = $urandom_range(1) ? 32'h7FFF_FFFF : $urandom;
      t = $urandom_range(1) ? 16'h0000 : 16'($urandom);
      l = 16'h0800 + 16'($urandom_range(1));
      ev <= e;
      dc <= d;
      tv <= t;
      ln <= l;
      @(posedge mclk_in);
      ev <= '0;
      x = expect_flags(e, d, t, l);
      rdc(8'h58, x);
      chk(flags, x);
      w = $urandom;
      xfer(1'b1, 8'h58, w);
      rdc(8'h58, x & ~w);
      xfer(1'b1, 8'h58, 32'hFFFF_FFFF);
    end
    // An error lands on the very edge that clears it.
    fork
      xfer(1'b1, 8'h58, 32'hFFFF_FFFF);
      begin
        @(posedge mclk_in);
        ev[11] <= 1'b1;
        @(posedge mclk_in);
        ev[11] <= 1'b0;
      end
    join
    rdc(8'h58, 32'h0000_4000);
    xfer(1'b1, 8'h58, 32'hFFFF_FFFF);
    phy <= 1'b1;
    xfer(1'b1, 8'h58, 32'hFFFF_FFFF);
    rdc(8'h58, 32'h0004_0000);
    phy <= 1'b0;
    rdc(8'h58, 32'h0000_0000);
    xfer(1'b1, 8'h74, 32'h0000_0001);
    rdc(8'h74, 32'h0000_0001);
    rdc(8'h70, 32'h8000_0000);
    xfer(1'b1, 8'h58, 32'h8000_0000);
    rdc(8'h58, 32'h8000_0000);
    xfer(1'b1, 8'h74, 32'h0000_0000);
    xfer(1'b1, 8'h58, 32'h8000_0000);
    rdc(8'h58, 32'h0000_0000);
    // Pin flags follow rising edges only, after the two-flop synchroniser.
    pins <= 3'b101;
    repeat (4) @(posedge mclk_in);
    xfer(1'b1, 8'h58, 32'h0000_0001);
    rdc(8'h58, 32'h0000_0004);
    pins <= 3'b010;
    repeat (4) @(posedge mclk_in);
    rdc(8'h58, 32'h0000_0006);
    xfer(1'b1, 8'h58, 32'h0000_0007);
    // A power event while asleep is flagged; a read of the test word does not wake.
    xfer(1'b1, 8'h74, 32'h0000_0002);
    ev[8] <= 1'b1;
    @(posedge mclk_in);
    ev[8] <= 1'b0;
    rdc(8'h58, 32'h0002_0000);
    rdc(8'h64, 32'h8765_4321);
    chk({31'h0, asleep}, 32'h0000_0001);
    xfer(1'b1, 8'h64, $urandom);
    chk({31'h0, asleep}, 32'h0000_0000);
    xfer(1'b1, 8'h58, 32'h0002_0000);
    rdc(8'h58, 32'h0000_0000);
    // With the clock enable low an error must not reach its flag.
    en <= 1'b0;
    ev[11] <= 1'b1;
    @(posedge mclk_in);
    ev[11] <= 1'b0;
    en <= 1'b1;
    @(posedge mclk_in);
    chk(flags, 32'h0000_0000);
    give_verdict();
  end
endmodule : eis_event_flags_bench

`default_nettype wire
